// ===== rtl/pol_pkg.sv
// Shared constants and types for the setpoint and sequencing block
package pol_pkg;

	// Register offsets on the byte register port
	localparam logic [7:0] ADDR_STARTUP_WAIT   = 8'h05;
	localparam logic [7:0] ADDR_SHUTDOWN_WAIT  = 8'h06;
	localparam logic [7:0] ADDR_DROOP          = 8'h08;
	localparam logic [7:0] ADDR_NOMINAL_UPPER  = 8'h0B;
	localparam logic [7:0] ADDR_NOMINAL_LOWER  = 8'h0C;
	localparam logic [7:0] ADDR_SECOND_UPPER   = 8'h0D;
	localparam logic [7:0] ADDR_SECOND_LOWER   = 8'h0E;
	localparam logic [7:0] ADDR_THIRD_UPPER    = 8'h0F;
	localparam logic [7:0] ADDR_THIRD_LOWER    = 8'h10;

	// Values after reset
	localparam logic [7:0]  RESET_STARTUP_WAIT  = 8'h00;
	localparam logic [5:0]  RESET_SHUTDOWN_WAIT = 6'h0B;
	localparam logic [2:0]  RESET_DROOP         = 3'h0;
	localparam logic [11:0] RESET_TARGET_CODE   = 12'h1E0;

	// Field layout
	localparam int SHUTDOWN_BITS = 6;
	localparam int TARGET_BITS   = 12;
	localparam int TARGET_LSB    = 4;
	localparam int DROOP_BITS    = 3;
	localparam int TARGET_COUNT  = 3;

	// Target range in 2.5 mV steps: 0.7 V and 5.5 V
	localparam logic [11:0] TARGET_MIN_CODE = 12'h118;
	localparam logic [11:0] TARGET_MAX_CODE = 12'h898;

	// Droop: slope step 0.74 mV/A, current in 1/16 A, LSB 2.5 mV
	// 0.74 / 16 / 2.5 = 0.0185, approximated by 19 / 1024
	localparam logic [4:0] DROOP_NUM   = 5'h13;
	localparam int         DROOP_SHIFT = 10;

	// Millisecond tick from the master clock
	localparam int CLK_FREQ_KHZ   = 40000;
	localparam int TICK_PERIOD_MS = 1;
	localparam int MS_TICK_CYCLES = TICK_PERIOD_MS * CLK_FREQ_KHZ;

	// Turn-on / turn-off sequence
	typedef enum logic [2:0] {
		SEQ_OFF,
		SEQ_ON_WAIT,
		SEQ_RUN,
		SEQ_OFF_WAIT,
		SEQ_RAMP_DOWN
	} pol_seq_t;

endpackage

// ===== rtl/pol_ms_tick.sv
// Free-running millisecond tick divided down from the master clock
module pol_ms_tick #(
	parameter int CYCLES = pol_pkg::MS_TICK_CYCLES
) (
	input  wire logic ref_clk,
	input  wire logic reset,
	output logic      tick
);
	import pol_pkg::*;

	initial begin
		if (CYCLES < 2)
			$error("pol_ms_tick: CYCLES must be at least 2");
	end

	typedef struct packed {
		logic [31:0] count; // Cycles since last tick
		logic        tick;  // One-cycle pulse
	} pol_tick_state_t;

	pol_tick_state_t cur;      // Registered state
	pol_tick_state_t next_cur; // Next state

	////////////////////////////////////////////////////////////////////////
	// Divider: shared master clock keeps all units in step
	always_comb begin
		next_cur = cur;
		next_cur.tick = 1'b0;
		if (cur.count == 32'(CYCLES - 1)) begin
			next_cur.count = 32'h0000_0000;
			next_cur.tick = 1'b1;
		end else begin
			next_cur.count = cur.count + 32'h0000_0001;
		end
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (reset)
			cur <= '0;
		else
			cur <= next_cur;
	end

	assign tick = cur.tick;
endmodule

// ===== rtl/pol_delay_ctr.sv
// Millisecond down-counter: loads a delay, pulses done when it expires
module pol_delay_ctr #(
	parameter int WIDTH = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             reset,
	input  wire logic             start,
	input  wire logic             abort,
	input  wire logic [WIDTH-1:0] load,
	input  wire logic             tick,
	output logic                  done,
	output logic                  busy
);
	import pol_pkg::*;

	initial begin
		if (WIDTH < 1 || WIDTH > 16)
			$error("pol_delay_ctr: WIDTH must be 1 to 16");
	end

	typedef struct packed {
		logic [WIDTH-1:0] remain; // Ticks still to wait
		logic             busy;   // Counting
		logic             done;   // Expiry pulse
	} pol_ctr_state_t;

	pol_ctr_state_t cur;      // Registered state
	pol_ctr_state_t next_cur; // Next state

	////////////////////////////////////////////////////////////////////////
	// Count down on ticks; a zero load expires at once, never wraps
	always_comb begin
		next_cur = cur;
		next_cur.done = 1'b0;
		if (abort) begin
			next_cur.busy = 1'b0;
		end else if (start) begin
			if (load == '0) begin
				next_cur.done = 1'b1;
				next_cur.busy = 1'b0;
			end else begin
				next_cur.remain = load;
				next_cur.busy = 1'b1;
			end
		end else if (cur.busy && tick) begin
			// Delay may run up to one tick short: tick is free-running
			if (cur.remain == WIDTH'(1)) begin
				next_cur.done = 1'b1;
				next_cur.busy = 1'b0;
			end
			next_cur.remain = cur.remain - WIDTH'(1);
		end
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (reset)
			cur <= '0;
		else
			cur <= next_cur;
	end

	assign done = cur.done;
	assign busy = cur.busy;
endmodule

// ===== rtl/pol_setpoint_seq.sv
// Output setpoint registers, droop and turn-on/turn-off delay sequencing
//
// What this block does
// - Targets 0.7 V to 5.5 V, 2.5 mV steps
// - Three targets: nominal, low and high margin
// - Upper byte shadowed; lower write commits word
// - Twelve-bit target, left-justified, low nibble unused
// - Targets change live while output runs
// - Eight droop slopes lower output with load
// - Turn-on waits programmed delay before ramping
// - Eight-bit turn-on delay in ms, resets zero
// - Off delay ends at zero or switches off
// - Pre-ramp wait is delay minus ramp time
// - Six-bit turn-off delay in ms, resets 11
// - Turn-off delay bits 7:6 read zero
// - Volatile registers return to defaults on reset
module pol_setpoint_seq #(
	parameter int          TICK_CYCLES = pol_pkg::MS_TICK_CYCLES,
	parameter logic [11:0] TARGET_RESET = pol_pkg::RESET_TARGET_CODE
) (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	output logic             reg_rvalid,
	input  wire logic        on_cmd,
	input  wire logic        off_cmd,
	input  wire logic [1:0]  margin_sel,
	input  wire logic [7:0]  load_current,
	input  wire logic        fall_slew_en,
	input  wire logic [7:0]  fall_ramp_ms,
	input  wire logic        out_zero_pin,
	output logic      [11:0] target_code,
	output logic             switch_enable,
	output logic             ramp_up_go,
	output logic             ramp_down_go,
	output logic             seq_busy
);
	import pol_pkg::*;

	initial begin
		if (TICK_CYCLES < 2)
			$error("pol_setpoint_seq: TICK_CYCLES must be at least 2");
		if (TARGET_RESET < TARGET_MIN_CODE || TARGET_RESET > TARGET_MAX_CODE)
			$error("pol_setpoint_seq: TARGET_RESET outside range");
	end

	////////////////////////////////////////////////////////////////////////
	// State of the block

	typedef struct packed {
		pol_seq_t                             seq;          // Sequence state
		logic [7:0]                           startup_wait; // Turn-on delay, ms
		logic [SHUTDOWN_BITS-1:0]             shutdown_wait; // Turn-off delay, ms
		logic [DROOP_BITS-1:0]                droop;        // Droop slope select
		logic [TARGET_COUNT-1:0][TARGET_BITS-1:0] target;   // Stored targets
		logic [7:0]                           shadow_upper; // Pending upper byte
		logic [7:0]                           read_lower;   // Lower byte latched on read
		logic [7:0]                           rdata;        // Read data
		logic                                 rvalid;       // Read answer pulse
		logic [11:0]                          out_code;     // Target after droop
		logic                                 sw_en;        // Switches enabled
		logic                                 busy;         // Sequence between end points
		logic                                 ramp_up;      // Start rising ramp
		logic                                 ramp_down;    // Start falling ramp
		logic                                 slew_off;     // Current off uses slew
		logic                                 on_start;     // Load turn-on counter
		logic                                 off_start;    // Load turn-off counter
		logic [7:0]                           off_load;     // Computed pre-ramp wait
		logic                                 zero_s1;      // Synchroniser, first
		logic                                 zero_s2;      // Synchroniser, second
	} pol_main_state_t;

	pol_main_state_t cur;      // Registered state
	pol_main_state_t next_cur; // Next state

	logic        tick;     // Millisecond tick
	logic        on_done;  // Turn-on delay expired
	logic        off_done; // Pre-ramp wait expired
	logic        abort;    // Cancel the running turn-on delay

	////////////////////////////////////////////////////////////////////////
	// Timing

	pol_ms_tick #(
		.CYCLES (TICK_CYCLES)
	) u_tick (
		.ref_clk (ref_clk),
		.reset   (reset),
		.tick    (tick)
	);

	pol_delay_ctr #(
		.WIDTH (8)
	) u_on_ctr (
		.ref_clk (ref_clk),
		.reset   (reset),
		.start   (cur.on_start),
		.abort   (abort),
		.load    (cur.startup_wait),
		.tick    (tick),
		.done    (on_done),
		.busy    ()
	);

	pol_delay_ctr #(
		.WIDTH (8)
	) u_off_ctr (
		.ref_clk (ref_clk),
		.reset   (reset),
		.start   (cur.off_start),
		.abort   (1'b0),
		.load    (cur.off_load),
		.tick    (tick),
		.done    (off_done),
		.busy    ()
	);

	// A turn-off during the turn-on wait cancels the pending turn-on
	assign abort = off_cmd && (cur.seq == SEQ_ON_WAIT);

	////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		logic [1:0]  idx;      // Selected target index
		logic [11:0] sel;      // Selected target
		logic [15:0] droop_p;  // Droop product
		logic [11:0] droop_o;  // Droop offset in LSBs
		logic [7:0]  full_off; // Turn-off delay widened

		idx = 2'h0;
		sel = 12'h000;
		droop_p = 16'h0000;
		droop_o = 12'h000;
		full_off = 8'h00;

		next_cur = cur;
		next_cur.rvalid = 1'b0;
		next_cur.ramp_up = 1'b0;
		next_cur.ramp_down = 1'b0;
		next_cur.on_start = 1'b0;
		next_cur.off_start = 1'b0;

		// Pin input through two flops
		next_cur.zero_s1 = out_zero_pin;
		next_cur.zero_s2 = cur.zero_s1;

		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				ADDR_STARTUP_WAIT: begin
					next_cur.startup_wait = reg_wdata;
				end
				ADDR_SHUTDOWN_WAIT: begin
					next_cur.shutdown_wait = reg_wdata[SHUTDOWN_BITS-1:0];
				end
				ADDR_DROOP: begin
					next_cur.droop = reg_wdata[DROOP_BITS-1:0];
				end
				ADDR_NOMINAL_UPPER, ADDR_SECOND_UPPER, ADDR_THIRD_UPPER: begin
					next_cur.shadow_upper = reg_wdata;
				end
				// Lower byte commits word, low nibble dropped
				ADDR_NOMINAL_LOWER: begin
					next_cur.target[0] = {cur.shadow_upper, reg_wdata[7:TARGET_LSB]};
				end
				ADDR_SECOND_LOWER: begin
					next_cur.target[1] = {cur.shadow_upper, reg_wdata[7:TARGET_LSB]};
				end
				ADDR_THIRD_LOWER: begin
					next_cur.target[2] = {cur.shadow_upper, reg_wdata[7:TARGET_LSB]};
				end
				// Writes elsewhere ignored
				default: begin
				end
			endcase
		end

		// Register reads, answered one cycle later
		if (reg_rd) begin
			next_cur.rvalid = 1'b1;
			case (reg_addr)
				ADDR_STARTUP_WAIT: begin
					next_cur.rdata = cur.startup_wait;
				end
				ADDR_SHUTDOWN_WAIT: begin
					next_cur.rdata = {2'h0, cur.shutdown_wait};
				end
				ADDR_DROOP: begin
					next_cur.rdata = {5'h00, cur.droop};
				end
				// Upper read latches lower half for a coherent pair
				ADDR_NOMINAL_UPPER: begin
					next_cur.rdata = cur.target[0][11:4];
					next_cur.read_lower = {cur.target[0][3:0], 4'h0};
				end
				ADDR_SECOND_UPPER: begin
					next_cur.rdata = cur.target[1][11:4];
					next_cur.read_lower = {cur.target[1][3:0], 4'h0};
				end
				ADDR_THIRD_UPPER: begin
					next_cur.rdata = cur.target[2][11:4];
					next_cur.read_lower = {cur.target[2][3:0], 4'h0};
				end
				// Lower byte returns the latched half
				ADDR_NOMINAL_LOWER, ADDR_SECOND_LOWER, ADDR_THIRD_LOWER: begin
					next_cur.rdata = cur.read_lower;
				end
				// Unmapped reads return zero
				default: begin
					next_cur.rdata = 8'h00;
				end
			endcase
		end

		// Margin select picks one of three targets
		case (margin_sel)
			2'h1:    idx = 2'h1;
			2'h2:    idx = 2'h2;
			default: idx = 2'h0;
		endcase
		sel = cur.target[idx];

		if (sel < TARGET_MIN_CODE)
			sel = TARGET_MIN_CODE;
		else if (sel > TARGET_MAX_CODE)
			sel = TARGET_MAX_CODE;

		// Output falls with load at the selected slope
		// Operands widened first so the product cannot overflow an 8-bit context
		droop_p = 16'(cur.droop) * 16'(load_current) * 16'(DROOP_NUM);
		droop_o = 12'(droop_p >> DROOP_SHIFT);

		// Target follows every committed write, even while running
		if (droop_o >= sel)
			next_cur.out_code = 12'h000;
		else
			next_cur.out_code = sel - droop_o;

		// Wait = delay minus ramp-down time; floor at zero
		full_off = {2'h0, cur.shutdown_wait};

		// Turn-on / turn-off sequence
		case (cur.seq)
			SEQ_OFF: begin
				if (on_cmd) begin
					next_cur.on_start = 1'b1;
					next_cur.seq = SEQ_ON_WAIT;
				end
			end
			SEQ_ON_WAIT: begin
				if (off_cmd) begin
					// Turn-off wins: output never started
					next_cur.seq = SEQ_OFF;
				end else if (on_done) begin
					// Delay over: enable and ramp up
					next_cur.sw_en = 1'b1;
					next_cur.ramp_up = 1'b1;
					next_cur.seq = SEQ_RUN;
				end
			end
			SEQ_RUN: begin
				if (off_cmd) begin
					next_cur.slew_off = fall_slew_en;
					next_cur.off_start = 1'b1;
					// Slewed off: subtract ramp time from delay
					if (fall_slew_en) begin
						// Ramp would overrun: start ramp at once
						if (fall_ramp_ms >= full_off)
							next_cur.off_load = 8'h00;
						else
							next_cur.off_load = full_off - fall_ramp_ms;
					end else begin
						// Plain off: whole delay to switch-off
						next_cur.off_load = full_off;
					end
					next_cur.seq = SEQ_OFF_WAIT;
				end
			end
			SEQ_OFF_WAIT: begin
				if (off_done) begin
					// Slewed: ramp down, end at zero output
					if (cur.slew_off) begin
						next_cur.ramp_down = 1'b1;
						next_cur.seq = SEQ_RAMP_DOWN;
					end else begin
						// Not slewed: both switches off now
						next_cur.sw_en = 1'b0;
						next_cur.seq = SEQ_OFF;
					end
				end
			end
			SEQ_RAMP_DOWN: begin
				// Delay ends once the output reaches zero
				if (cur.zero_s2) begin
					next_cur.sw_en = 1'b0;
					next_cur.seq = SEQ_OFF;
				end
			end
			default: begin
				next_cur.sw_en = 1'b0;
				next_cur.seq = SEQ_OFF;
			end
		endcase

		// Busy registered from the next state, so the port comes from a flop
		next_cur.busy = (next_cur.seq == SEQ_ON_WAIT) || (next_cur.seq == SEQ_OFF_WAIT)
			|| (next_cur.seq == SEQ_RAMP_DOWN);
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cur <= '0;
			cur.seq <= SEQ_OFF;
			cur.startup_wait <= RESET_STARTUP_WAIT;
			cur.shutdown_wait <= RESET_SHUTDOWN_WAIT;
			cur.droop <= RESET_DROOP;
			cur.target <= {TARGET_COUNT{TARGET_RESET}};
			cur.out_code <= TARGET_RESET;
		end else begin
			cur <= next_cur;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, straight from flops

	assign reg_rdata = cur.rdata;
	assign reg_rvalid = cur.rvalid;
	assign target_code = cur.out_code;
	assign switch_enable = cur.sw_en;
	assign ramp_up_go = cur.ramp_up;
	assign ramp_down_go = cur.ramp_down;
	// Busy whenever a sequence is between its end points
	assign seq_busy = cur.busy;
endmodule

// ===== bench/pol_setpoint_seq_chk.sv
// Port-level assertions for the setpoint and sequencing block
module pol_setpoint_seq_chk (
	input wire logic        ref_clk,
	input wire logic        reset,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic [7:0]  reg_rdata,
	input wire logic        reg_rvalid,
	input wire logic        on_cmd,
	input wire logic        off_cmd,
	input wire logic [1:0]  margin_sel,
	input wire logic [7:0]  load_current,
	input wire logic        fall_slew_en,
	input wire logic [7:0]  fall_ramp_ms,
	input wire logic        out_zero_pin,
	input wire logic [11:0] target_code,
	input wire logic        switch_enable,
	input wire logic        ramp_up_go,
	input wire logic        ramp_down_go,
	input wire logic        seq_busy
);
	timeunit 1ns;
	timeprecision 100ps;
	import pol_pkg::*;

	// One clock domain, so one default clock and reset
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);

	////////////////////////////////////////////////////////////////////////////
	chk_read_answer:
	assert property (reg_rd |=> reg_rvalid) else $error("read got no answer");
	chk_answer_cause:
	assert property (reg_rvalid |-> $past(reg_rd)) else $error("answer without read");
	chk_rdata_hold:
	assert property (!reg_rvalid |-> $stable(reg_rdata)) else $error("read data moved");
	chk_target_ceiling:
	assert property (target_code <= TARGET_MAX_CODE) else $error("target above range");
	chk_ramp_switch:
	assert property (ramp_up_go |-> $rose(switch_enable)) else $error("ramp without switch");
	chk_ramp_pulse:
	assert property (ramp_up_go |=> !ramp_up_go) else $error("ramp pulse too long");
	chk_down_switch:
	assert property (ramp_down_go |-> switch_enable ##1 (switch_enable && !ramp_down_go)
		##1 switch_enable) else $error("switches off during ramp");
	chk_on_taken:
	assert property ((on_cmd && !seq_busy && !switch_enable) |-> ##[1:2] seq_busy)
		else $error("turn-on not taken");
	chk_off_refused:
	assert property ((off_cmd && !on_cmd && !seq_busy && !switch_enable)
		|=> (!seq_busy && !switch_enable)) else $error("turn-off acted while off");
endmodule

bind pol_setpoint_seq pol_setpoint_seq_chk i_pol_setpoint_seq_chk (.ref_clk, .reset, .reg_wr,
	.reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .on_cmd, .off_cmd, .margin_sel,
	.load_current, .fall_slew_en, .fall_ramp_ms, .out_zero_pin, .target_code, .switch_enable,
	.ramp_up_go, .ramp_down_go, .seq_busy);

// ===== bench/pol_mgr_model.sv
// Power manager model: byte register access and output rail zero sense
module pol_mgr_model #(
	parameter int ZDLY = 6
) (
	input  wire logic       ref_clk,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid,
	input  wire logic       ramp_up_go,
	input  wire logic       ramp_down_go,
	output logic            out_zero_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	int zc = 0; // Cycles until the rail reads zero

	// Idle bus, rail starts discharged
	initial begin
		reg_wr = 0;
		reg_rd = 0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		out_zero_pin = 1;
	end

	////////////////////////////////////////////////////////////////////////////
	// One byte write; bus shows junk once released
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_wr = 1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge ref_clk);
		reg_wr = 0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask

	// One byte read; answer taken one cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(negedge ref_clk);
		reg_rd = 1;
		reg_addr = a;
		@(negedge ref_clk);
		reg_rd = 0;
		reg_addr = ~a;
		d = reg_rdata;
		v = reg_rvalid;
	endtask

	// Rail leaves zero on ramp up, reaches zero a while after ramp down
	always @(negedge ref_clk) begin
		if (ramp_up_go === 1'b1) out_zero_pin = 0;
		if (ramp_down_go === 1'b1) zc = ZDLY;
		else if (zc > 1) zc--;
		else if (zc == 1) begin
			zc = 0;
			out_zero_pin = 1;
		end
	end
endmodule

// ===== bench/pol_setpoint_seq_tb_top.sv
// Self-checking bench for the setpoint and sequencing block
module pol_setpoint_seq_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import pol_pkg::*;

	`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
		$display("[ERR] %s exp %0h got %0h", nm, e, g); end end

	localparam int TICK = 4; // Short millisecond for simulation
	localparam int ZDLY = 6; // Model rail discharge cycles
	logic        ref_clk = 0, reset = 1, on_cmd = 0, off_cmd = 0, fall_slew_en = 0;
	logic [1:0]  margin_sel = 0;
	logic [7:0]  load_current = 0, fall_ramp_ms = 0;
	logic        reg_wr, reg_rd, reg_rvalid, out_zero_pin;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata;
	logic [11:0] target_code;
	logic        switch_enable, ramp_up_go, ramp_down_go, seq_busy;
	logic [11:0] tg [3]; // Last written code of each target
	int          bad_count = 0, n_compared = 0;

	// 40 MHz master clock
	always #12.5 ref_clk = ~ref_clk;

	pol_setpoint_seq #(.TICK_CYCLES(TICK)) i_pol_setpoint_seq (.ref_clk, .reset, .reg_wr,
		.reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .on_cmd, .off_cmd, .margin_sel,
		.load_current, .fall_slew_en, .fall_ramp_ms, .out_zero_pin, .target_code,
		.switch_enable, .ramp_up_go, .ramp_down_go, .seq_busy);
	pol_mgr_model #(.ZDLY(ZDLY)) i_pol_mgr_model (.ref_clk, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .reg_rdata, .reg_rvalid, .ramp_up_go, .ramp_down_go, .out_zero_pin);

	////////////////////////////////////////////////////////////////////////////
	// Expected output code: clamp to range, then droop, floored at zero
	function automatic logic [11:0] exp_tgt(logic [11:0] c, int k, int l);
		int cl;
		int d;
		cl = (c < TARGET_MIN_CODE) ? TARGET_MIN_CODE : (c > TARGET_MAX_CODE) ? TARGET_MAX_CODE : c;
		d = (k * l * 19) >> 10;
		return (cl > d) ? 12'(cl - d) : 12'h000;
	endfunction

	// Verdict in one place
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// Read a register and compare
	task automatic rchk(string nm, logic [7:0] a, logic [7:0] e);
		logic [7:0] d;
		logic       v;
		i_pol_mgr_model.rd(a, d, v);
		`CHK(nm, 1'b1, v)
		`CHK(nm, e, d)
	endtask

	task automatic set_tgt(int idx, logic [11:0] c, logic [3:0] junk);
		i_pol_mgr_model.wr(ADDR_NOMINAL_UPPER + 8'(2 * idx), c[11:4]);
		i_pol_mgr_model.wr(ADDR_NOMINAL_LOWER + 8'(2 * idx), {c[3:0], junk});
		tg[idx] = c;
	endtask

	// Issue a command (1 on, 2 off, 0 none), count cycles to an event
	task automatic go(int cmd, int sel, int lo, int hi);
		int k;
		bit hit;
		@(negedge ref_clk);
		if (cmd == 1) on_cmd = 1;
		if (cmd == 2) off_cmd = 1;
		k = 0;
		hit = 0;
		while (!hit) begin
			@(negedge ref_clk);
			on_cmd = 0;
			off_cmd = 0;
			k++;
			hit = (sel == 0) ? ramp_up_go === 1'b1 :
				(sel == 1) ? switch_enable === 1'b0 : ramp_down_go === 1'b1;
			// Hung sequence ends the run
			if (k > 3000) begin
				bad_count++;
				report_and_stop;
			end
		end
		`CHK("seq delay", 1'b1, (k >= lo && k <= hi))
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h722f281c));
		repeat (20) @(negedge ref_clk);
		reset = 0;
		// Defaults, then again after a mid-run reset
		for (int p = 0; p < 2; p++) begin
			rchk("startup", ADDR_STARTUP_WAIT, 8'h00);
			rchk("shutdown", ADDR_SHUTDOWN_WAIT, 8'h0B);
			rchk("droop", ADDR_DROOP, 8'h00);
			rchk("unmapped", 8'h20, 8'h00);
			rchk("upper", ADDR_SECOND_UPPER, RESET_TARGET_CODE[11:4]);
			rchk("lower", ADDR_SECOND_LOWER, {RESET_TARGET_CODE[3:0], 4'h0});
			`CHK("target", RESET_TARGET_CODE, target_code)
			if (p == 0) begin
				i_pol_mgr_model.wr(ADDR_SHUTDOWN_WAIT, 8'h22);
				i_pol_mgr_model.wr(ADDR_STARTUP_WAIT, 8'h07);
				set_tgt(0, 12'h300, 4'h0);
				reset = 1;
				repeat (2) @(negedge ref_clk);
				reset = 0;
			end
		end
		i_pol_mgr_model.wr(ADDR_SHUTDOWN_WAIT, 8'hFF);
		rchk("shutdown", ADDR_SHUTDOWN_WAIT, 8'h3F);
		// lone unit, no parallel group to join
		// Random targets, out-of-range corners first
		for (int i = 0; i < 9; i++) begin
			logic [11:0] c;
			c = (i == 0) ? 12'h050 : (i == 1) ? 12'hFFF : 12'h118 + 12'($urandom_range(0, 1920));
			margin_sel = 2'(i % 3);
			set_tgt(i % 3, c, 4'($urandom));
			repeat (3) @(negedge ref_clk);
			rchk("t upper", ADDR_NOMINAL_UPPER + 8'(2 * (i % 3)), c[11:4]);
			rchk("t lower", ADDR_NOMINAL_LOWER + 8'(2 * (i % 3)), {c[3:0], 4'h0});
			`CHK("target", exp_tgt(c, 0, 0), target_code)
		end
		margin_sel = 2'd3;
		repeat (2) @(negedge ref_clk);
		`CHK("target", exp_tgt(tg[0], 0, 0), target_code)
		margin_sel = 2'd0;
		i_pol_mgr_model.wr(ADDR_NOMINAL_UPPER, ~tg[0][11:4]);
		repeat (3) @(negedge ref_clk);
		`CHK("shadow", exp_tgt(tg[0], 0, 0), target_code)
		// lone unit, no follower slopes
		// Every droop slope with a random load
		for (int k = 0; k < 8; k++) begin
			int l;
			l = $urandom_range(0, 255);
			load_current = 8'(l);
			i_pol_mgr_model.wr(ADDR_DROOP, 8'(k));
			repeat (3) @(negedge ref_clk);
			`CHK("droop", exp_tgt(tg[0], k, l), target_code)
		end
		load_current = 8'h00;
		i_pol_mgr_model.wr(ADDR_DROOP, 8'h00);
		// Turn on after three ms, retarget live, turn off without slew
		i_pol_mgr_model.wr(ADDR_STARTUP_WAIT, 8'h03);
		go(1, 0, 2 * TICK + 2, 3 * TICK + 5);
		`CHK("switch", 1'b1, switch_enable)
		set_tgt(0, 12'h640, 4'h0);
		repeat (3) @(negedge ref_clk);
		`CHK("live target", 12'h640, target_code)
		i_pol_mgr_model.wr(ADDR_SHUTDOWN_WAIT, 8'h02);
		go(2, 1, TICK + 2, 2 * TICK + 5);
		i_pol_mgr_model.wr(ADDR_STARTUP_WAIT, 8'h00);
		go(1, 0, 3, 3);
		fall_slew_en = 1;
		fall_ramp_ms = 8'h02;
		i_pol_mgr_model.wr(ADDR_SHUTDOWN_WAIT, 8'h05);
		go(2, 2, 2 * TICK + 2, 3 * TICK + 5);
		go(0, 1, ZDLY, ZDLY + 8);
		go(1, 0, 3, 3);
		fall_ramp_ms = 8'h09;
		go(2, 2, 1, 5);
		go(0, 1, ZDLY, ZDLY + 8);
		// Turn-off during the turn-on wait cancels it
		i_pol_mgr_model.wr(ADDR_STARTUP_WAIT, 8'h03);
		@(negedge ref_clk);
		on_cmd = 1;
		@(negedge ref_clk);
		on_cmd = 0;
		off_cmd = 1;
		@(negedge ref_clk);
		off_cmd = 0;
		repeat (20) @(negedge ref_clk);
		`CHK("cancel switch", 1'b0, switch_enable)
		`CHK("cancel busy", 1'b0, seq_busy)
		// Turn-off while already off does nothing
		@(negedge ref_clk);
		off_cmd = 1;
		@(negedge ref_clk);
		off_cmd = 0;
		repeat (3) @(negedge ref_clk);
		`CHK("idle busy", 1'b0, seq_busy)
		report_and_stop;
	end
endmodule
